/* File: hdl/fsl_top.sv */
/*
 * program flash access and self-programming sequencer: table reads and
 * writes from the core, holding latches, unlock key, row program, word
 * program and block erase over an on-chip array model.
 * assumes a processor core on the same clock driving the table port and
 * the plain register port; reads of the register port answer one cycle later.
 *
 */
// Our own choices: the address-and-strobe port and the address map.
`include "fsl_params.svh"
`default_nettype none

module fsl_top
    import fsl_pkg::*;
#(
    parameter int FLASH_WORDS = 8192,
    parameter int FA_W = 13,
    parameter int CFG_WORDS = 8,
    parameter logic [23:0] CFG_DEFAULT = 24'hffffff,
    parameter int SETTLE_CYC = `FSL_SETTLE_CYC
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    input wire fsl_tbl_req_t tbl_req,
    output fsl_tbl_rsp_t tbl_rsp,
    output logic tbl_busy,
    output logic cpu_stall
);

    typedef struct packed {
        fsl_state_e_t st;
        logic [7:0] page;
        logic go;
        logic wren;
        logic err;
        fsl_op_e_t op;
        fsl_key_e_t key;
        logic [8:0] idx;
        logic [8:0] last_idx;
        logic [22:0] base;
        logic [22:0] last_wr;
        fsl_tbl_req_t req;
        logic [23:0] addr;
        fsl_tbl_rsp_t rsp;
        logic busy;
        logic stall;
        logic [15:0] rdata;
        logic tmr_start;
    } fsl_top_state_t;

    fsl_top_state_t s_q;
    fsl_top_state_t s_d;

    // nonvolatile, so no reset
    logic [23:0] flash_mem [FLASH_WORDS];
    logic [23:0] cfg_mem [CFG_WORDS];

    logic [5:0] lat_idx;
    logic lat_we;
    logic [2:0] lat_be;
    logic [23:0] lat_wdata;
    logic [23:0] lat_rdata;
    logic tmr_done;
    logic flash_we;
    logic [FA_W-1:0] flash_wa;
    logic [23:0] flash_wd;
    logic [22:0] prog_word;
    logic [FA_W-1:0] rd_wa;
    logic [23:0] rd_word;

    fsl_latch_row #(
        .ENTRIES(`FSL_ROW_WORDS),
        .IW(6)
    ) u_latch (
        .clk(clk),
        .we(lat_we),
        .idx(lat_idx),
        .be(lat_be),
        .wdata(lat_wdata),
        .rdata(lat_rdata)
    );

    fsl_busy_timer #(
        .W(16)
    ) u_timer (
        .clk(clk),
        .rst(rst),
        .start(s_q.tmr_start),
        .load(16'(SETTLE_CYC)),
        .done(tmr_done)
    );

    initial begin
        for (int i = 0; i < CFG_WORDS; i++) begin
            cfg_mem[i] = CFG_DEFAULT;
        end
    end

    // word index of the latched table address
    assign rd_wa = FA_W'(s_q.addr[23:1]);

    always_comb begin
        if (s_q.addr[23]) begin
            rd_word = cfg_mem[s_q.addr[1 +: $clog2(CFG_WORDS)]];
        end else begin
            rd_word = flash_mem[rd_wa];
        end
    end

    // word address programmed or erased in the current loop step
    assign prog_word = s_q.base + {14'h0, s_q.idx};
    assign flash_wa = FA_W'(prog_word);

    always_comb begin
        if (s_q.op == FSL_OP_ERASE) begin
            flash_wd = `FSL_ERASED;
        end else begin
            // bits only fall to zero, hence the erase before reprogramming
            flash_wd = flash_mem[flash_wa] & lat_rdata;
        end
    end

    assign flash_we = (s_q.st == FSL_ST_PROG) && !prog_word[22];

    always_ff @(posedge clk) begin
        if (flash_we) begin
            flash_mem[flash_wa] <= flash_wd;
        end
    end

    // latch port: table write in its second cycle, otherwise program loop
    always_comb begin
        lat_we = 1'b0;
        lat_be = 3'b000;
        lat_wdata = 24'h000000;
        lat_idx = prog_word[5:0];
        if (s_q.st == FSL_ST_TBL) begin
            lat_idx = s_q.addr[6:1];
            if (s_q.req.write && !s_q.addr[23]) begin
                lat_we = 1'b1;
                if (s_q.req.high) begin
                    lat_be = {!(s_q.req.byte_mode && s_q.addr[0]), 2'b00};
                    lat_wdata = {s_q.req.wdata[7:0], 16'h0000};
                end else if (!s_q.req.byte_mode) begin
                    lat_be = 3'b011;
                    lat_wdata = {8'h00, s_q.req.wdata};
                end else if (s_q.addr[0]) begin
                    lat_be = 3'b010;
                    lat_wdata = {8'h00, s_q.req.wdata[7:0], 8'h00};
                end else begin
                    lat_be = 3'b001;
                    lat_wdata = {16'h0000, s_q.req.wdata[7:0]};
                end
            end
        end
    end

    always_comb begin
        s_d = s_q;
        s_d.rsp.done = 1'b0;
        s_d.tmr_start = 1'b0;
        s_d.rdata = 16'h0000;

        // register port
        if (reg_rd) begin
            if (reg_addr == `FSL_OFS_PAGE) begin
                s_d.rdata = {8'h00, s_q.page};
            end else if (reg_addr == `FSL_OFS_CTL) begin
                s_d.rdata = {s_q.go, s_q.wren, s_q.err, 11'h000, s_q.op};
            end else begin
                s_d.rdata = 16'h0000;
            end
        end
        if (reg_wr) begin
            s_d.key = FSL_KEY_IDLE;
            if (reg_addr == `FSL_OFS_PAGE) begin
                s_d.page = reg_wdata[7:0];
            end else if (reg_addr == `FSL_OFS_CTL) begin
                if (s_q.st != FSL_ST_PROG && s_q.st != FSL_ST_WAIT) begin
                    s_d.wren = reg_wdata[`FSL_CTL_WREN];
                    s_d.op = fsl_op_e_t'(reg_wdata[`FSL_CTL_OP_HI:`FSL_CTL_OP_LO]);
                    s_d.err = reg_wdata[`FSL_CTL_ERR] & s_q.err;
                end
                if (reg_wdata[`FSL_CTL_GO] && s_q.st == FSL_ST_IDLE) begin
                    if (s_q.key == FSL_KEY_OPEN && reg_wdata[`FSL_CTL_WREN]
                            && reg_wdata[1:0] != 2'b00) begin
                        s_d.go = 1'b1;
                        s_d.st = FSL_ST_PROG;
                        s_d.idx = 9'h000;
                        s_d.busy = 1'b1;
                        s_d.stall = 1'b1;
                        case (fsl_op_e_t'(reg_wdata[1:0]))
                            FSL_OP_WORD: begin
                                s_d.base = s_q.last_wr;
                                s_d.last_idx = 9'h000;
                            end
                            FSL_OP_ROW: begin
                                s_d.base = {s_q.last_wr[22:6], 6'h00};
                                s_d.last_idx = 9'(`FSL_ROW_WORDS - 1);
                            end
                            default: begin
                                s_d.base = {s_q.last_wr[22:9], 9'h000};
                                s_d.last_idx = 9'(`FSL_BLOCK_WORDS - 1);
                            end
                        endcase
                    end else begin
                        s_d.err = 1'b1;
                    end
                end
            end else if (reg_addr == `FSL_OFS_KEY) begin
                if (reg_wdata[7:0] == `FSL_KEY_FIRST) begin
                    s_d.key = FSL_KEY_HALF;
                end else if (s_q.key == FSL_KEY_HALF && reg_wdata[7:0] == `FSL_KEY_SECOND) begin
                    s_d.key = FSL_KEY_OPEN;
                end
            end
        end

        // sequencer
        case (s_q.st)
            FSL_ST_IDLE: begin
                if (tbl_req.valid && s_d.st == FSL_ST_IDLE) begin
                    s_d.req = tbl_req;
                    s_d.addr = {s_q.page, tbl_req.ea};
                    s_d.st = FSL_ST_TBL;
                    s_d.busy = 1'b1;
                end
            end
            FSL_ST_TBL: begin
                s_d.st = FSL_ST_IDLE;
                s_d.busy = 1'b0;
                s_d.rsp.done = 1'b1;
                s_d.rsp.rdata = 16'h0000;
                if (s_q.req.write) begin
                    if (!s_q.addr[23]) begin
                        s_d.last_wr = s_q.addr[23:1];
                    end
                end else if (s_q.req.high) begin
                    s_d.rsp.rdata = (s_q.req.byte_mode && s_q.addr[0]) ? 16'h0000
                        : {8'h00, rd_word[23:16]};
                end else if (!s_q.req.byte_mode) begin
                    s_d.rsp.rdata = rd_word[15:0];
                end else begin
                    s_d.rsp.rdata = {8'h00, s_q.addr[0] ? rd_word[15:8] : rd_word[7:0]};
                end
            end
            FSL_ST_PROG: begin
                s_d.idx = s_q.idx + 9'h001;
                if (s_q.idx == s_q.last_idx) begin
                    s_d.st = FSL_ST_WAIT;
                    s_d.tmr_start = 1'b1;
                end
            end
            FSL_ST_WAIT: begin
                if (tmr_done) begin
                    s_d.go = 1'b0;
                    s_d.st = FSL_ST_IDLE;
                    s_d.busy = 1'b0;
                    s_d.stall = 1'b0;
                end
            end
            default: begin
                s_d.st = FSL_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_q <= '0;
            s_q.st <= FSL_ST_IDLE;
            s_q.key <= FSL_KEY_IDLE;
            s_q.op <= FSL_OP_NONE;
            s_q.page <= `FSL_PAGE_RST;
        end else begin
            s_q <= s_d;
        end
    end

    assign reg_rdata = s_q.rdata;
    assign tbl_rsp = s_q.rsp;
    assign tbl_busy = s_q.busy;
    assign cpu_stall = s_q.stall;

endmodule // fsl_top

`default_nettype wire

/* File: hdl/fsl_params.svh */
/*
 * constants of the flash self-programming block: register offsets, field
 * positions, reset values, geometry and timing counts.
 * assumes a 20 MHz system clock and a 4-bit register address port.
 */
`ifndef FSL_PARAMS_SVH
`define FSL_PARAMS_SVH

// register offsets on the plain register port
`define FSL_OFS_PAGE 4'h0
`define FSL_OFS_CTL 4'h2
`define FSL_OFS_KEY 4'h4

// flash_op_control fields
`define FSL_CTL_GO 15
`define FSL_CTL_WREN 14
`define FSL_CTL_ERR 13
`define FSL_CTL_OP_HI 1
`define FSL_CTL_OP_LO 0

// reset values
`define FSL_PAGE_RST 8'h00

// unlock keys, in order
`define FSL_KEY_FIRST 8'h55
`define FSL_KEY_SECOND 8'haa

// geometry in instruction words, and the erased word value
`define FSL_ROW_WORDS 64
`define FSL_BLOCK_WORDS 512
`define FSL_ERASED 24'hffffff

// timing
`define FSL_CLK_MHZ 20
`define FSL_SETTLE_TIME_NS 2000
`define FSL_SETTLE_CYC ((`FSL_SETTLE_TIME_NS * `FSL_CLK_MHZ + 999) / 1000)

`endif

/* File: hdl/fsl_pkg.sv */
/*
 * types of the flash self-programming block: states, operations and the
 * table port carriers.
 * assumes fsl_params.svh is available to the modules that use it.
 */
`default_nettype none

package fsl_pkg;

    typedef enum logic [3:0] {
        FSL_ST_IDLE = 4'b0001,
        FSL_ST_TBL = 4'b0010,
        FSL_ST_PROG = 4'b0100,
        FSL_ST_WAIT = 4'b1000
    } fsl_state_e_t;

    typedef enum logic [2:0] {
        FSL_KEY_IDLE = 3'b001,
        FSL_KEY_HALF = 3'b010,
        FSL_KEY_OPEN = 3'b100
    } fsl_key_e_t;

    typedef enum logic [1:0] {
        FSL_OP_NONE = 2'b00,
        FSL_OP_WORD = 2'b01,
        FSL_OP_ROW = 2'b10,
        FSL_OP_ERASE = 2'b11
    } fsl_op_e_t;

    typedef struct packed {
        logic valid;
        logic write;
        logic high;
        logic byte_mode;
        logic [15:0] ea;
        logic [15:0] wdata;
    } fsl_tbl_req_t;

    typedef struct packed {
        logic done;
        logic [15:0] rdata;
    } fsl_tbl_rsp_t;

endpackage

`default_nettype wire

/* File: hdl/fsl_latch_row.sv */
/*
 * row of write holding latches, one 24-bit entry per instruction word,
 * byte-lane writes, combinational read.
 * assumes writer and reader share one index; no reset on purpose.
 */
`default_nettype none

module fsl_latch_row #(
    parameter int ENTRIES = 64,
    parameter int IW = 6
) (
    input wire logic clk,
    input wire logic we,
    input wire logic [IW-1:0] idx,
    input wire logic [2:0] be,
    input wire logic [23:0] wdata,
    output logic [23:0] rdata
);

    // contents are unknown after power-up, software must fill gaps
    logic [23:0] mem [ENTRIES];

    always_ff @(posedge clk) begin
        for (int b = 0; b < 3; b++) begin
            if (we && be[b]) begin
                mem[idx][b*8 +: 8] <= wdata[b*8 +: 8];
            end
        end
    end

    assign rdata = mem[idx];

endmodule // fsl_latch_row

`default_nettype wire

/* File: hdl/fsl_busy_timer.sv */
/*
 * one-shot down counter: a start pulse loads it, done pulses once when the count is down to one.
 * assumes start is a one-cycle pulse on the system clock.
 */
`default_nettype none

module fsl_busy_timer #(
    parameter int W = 16
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic start,
    input wire logic [W-1:0] load,
    output logic done
);

    logic [W-1:0] cnt_q;
    logic run_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_q <= '0;
            run_q <= 1'b0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start) begin
                cnt_q <= load;
                run_q <= 1'b1;
            end else if (run_q) begin
                if (cnt_q <= W'(1)) begin
                    run_q <= 1'b0;
                    done <= 1'b1;
                end else begin
                    cnt_q <= cnt_q - W'(1);
                end
            end
        end
    end

endmodule // fsl_busy_timer

`default_nettype wire

/* File: sim/fsl_monitor.sv */
/* checker on the fsl_top ports, bound below.
   assumes one clock domain and rst async active high. */
`default_nettype none
module fsl_monitor
    import fsl_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire fsl_tbl_req_t tbl_req,
    input wire fsl_tbl_rsp_t tbl_rsp,
    input wire logic tbl_busy,
    input wire logic cpu_stall
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    logic half_q, open_q, go_wr, take;
    // a go write that starts an operation drops a table request in the same cycle
    assign go_wr = reg_wr && reg_addr == 4'h2 && reg_wdata[15];
    assign take = tbl_req.valid && !tbl_busy && !go_wr;
    // any other write between the keys breaks the unlock
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            half_q <= 1'b0;
            open_q <= 1'b0;
        end else if (reg_wr) begin
            half_q <= reg_addr == 4'h4 && reg_wdata[7:0] == 8'h55;
            open_q <= reg_addr == 4'h4 && reg_wdata[7:0] == 8'haa && half_q;
        end
    end
    a_done_two: assert property (take |-> ##2 tbl_rsp.done)
        else $error("table op done not two cycles after take");
    a_done_cause: assert property (tbl_rsp.done |-> $past(tbl_req.valid, 2))
        else $error("done without request");
    a_busy_one: assert property (take |=> tbl_busy ##1 !tbl_busy)
        else $error("busy not exactly one cycle");
    a_key_zero: assert property (reg_rd && reg_addr == 4'h4 |=> reg_rdata == 16'h0000)
        else $error("key register readable");
    a_go_locked: assert property (go_wr && !open_q && !cpu_stall |=> !cpu_stall)
        else $error("operation started while locked");
    a_go_start: assert property (go_wr && reg_wdata[14] && reg_wdata[1:0] != 2'b00
        && open_q && !tbl_busy |=> cpu_stall) else $error("unlocked go ignored");
    a_stall_busy: assert property (cpu_stall |-> tbl_busy)
        else $error("stall without busy");
    a_stall_ends: assert property ($rose(cpu_stall) |-> ##[1:600] !cpu_stall)
        else $error("operation never ends");
    a_stall_drop: assert property (tbl_req.valid && cpu_stall |-> ##2 !tbl_rsp.done)
        else $error("table op served while stalled");
    c_table: cover property (take ##2 tbl_rsp.done);
    c_op_end: cover property ($fell(cpu_stall));
    c_drop: cover property (tbl_req.valid && cpu_stall);
endmodule // fsl_monitor
bind fsl_top fsl_monitor mon (.clk(clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .tbl_req(tbl_req), .tbl_rsp(tbl_rsp), .tbl_busy(tbl_busy), .cpu_stall(cpu_stall));
`default_nettype wire

/* File: sim/fsl_core_model.sv */
/* processor core model issuing table reads and writes.
   assumes the caller waits out program and erase before op. */
`default_nettype none
module fsl_core_model
    import fsl_pkg::*;
(
    input wire logic clk,
    input wire fsl_tbl_rsp_t tbl_rsp,
    output fsl_tbl_req_t tbl_req
);
    timeunit 1ns;
    timeprecision 1ns;
    initial tbl_req = '0;
    task automatic op(input logic wr, hi, bm, input logic [15:0] ea, wd,
        output logic [15:0] rd);
        int n;
        @(posedge clk);
        tbl_req <= '{1'b1, wr, hi, bm, ea, wd};
        @(posedge clk);
        // request taken at this edge; released lines must not look like it
        tbl_req <= '{1'b0, wr, hi, bm, ~ea, ~wd};
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (!tbl_rsp.done && n < 8);
        rd = tbl_rsp.rdata;
    endtask
    // request that ignores the stall, to be refused
    task automatic poke();
        @(posedge clk);
        tbl_req.valid <= 1'b1;
        @(posedge clk);
        tbl_req.valid <= 1'b0;
    endtask
endmodule // fsl_core_model
`default_nettype wire

/* File: sim/tb_top.sv */
/* self-checking bench for fsl_top with a core model on the table port.
   assumes settle count shortened to 2 cycles. */
`default_nettype none
module tb_top
    import fsl_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, rst, reg_wr, reg_rd, tbl_busy, cpu_stall;
    logic [3:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata, v;
    logic [23:0] w;
    logic [15:0] eb [4] = '{16'h0000, 16'h03fe, 16'h0400, 16'h07fe};
    fsl_tbl_req_t tbl_req;
    fsl_tbl_rsp_t tbl_rsp;
    int num_errors = 0;
    int tests_run = 0;
    int cyc = 0;
    fsl_top #(.SETTLE_CYC(2)) dut (.clk(clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .tbl_req(tbl_req), .tbl_rsp(tbl_rsp), .tbl_busy(tbl_busy), .cpu_stall(cpu_stall));
    fsl_core_model core (.clk(clk), .tbl_rsp(tbl_rsp), .tbl_req(tbl_req));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task automatic final_report();
        $display("errors %0d checks %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            num_errors++;
            final_report();
        end
    end
    task automatic check(input logic [23:0] got, exp);
        tests_run++;
        if (got !== exp) begin
            $display("Error at %0t: got %h expected %h", $time, got, exp);
            num_errors++;
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task automatic tww(input logic [15:0] ea, input logic [23:0] d);
        logic [15:0] x;
        core.op(1'b1, 1'b0, 1'b0, ea, d[15:0], x);
        core.op(1'b1, 1'b1, 1'b0, ea, {8'h00, d[23:16]}, x);
    endtask
    task automatic cw(input logic [15:0] ea, input logic [23:0] exp);
        logic [15:0] lo, hi;
        core.op(1'b0, 1'b0, 1'b0, ea, 16'h0000, lo);
        core.op(1'b0, 1'b1, 1'b0, ea, 16'h0000, hi);
        check({hi[7:0], lo}, exp);
    endtask
    task automatic go(input logic [1:0] op, input bit pk);
        int n;
        wr(4'h4, 16'h0055);
        wr(4'h4, 16'h00aa);
        wr(4'h2, {14'h3000, op});
        #1 check(24'(cpu_stall), 24'h000001);
        if (pk)
            core.poke();
        n = 0;
        while (cpu_stall && n < 1000) begin
            @(posedge clk);
            #1;
            n++;
        end
        rd(4'h2, v);
        check(24'(v[15]), 24'h000000);
    endtask
    initial begin
        rst = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 4'h0;
        reg_wdata = 16'h0000;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        for (int a = 0; a < 8; a += 2) begin
            rd(4'(a), v);
            check(24'(v), 24'h000000);
        end
        wr(4'h0, 16'h00a5);
        rd(4'h0, v);
        check(24'(v), 24'h0000a5);
        wr(4'h0, 16'h0000);
        $display("test reset finished");
        wr(4'h2, 16'hc002);
        rd(4'h2, v);
        check(24'(v & 16'ha000), 24'h002000);
        wr(4'h2, 16'h0000);
        // a page write between the keys relocks
        wr(4'h4, 16'h0055);
        wr(4'h0, 16'h0000);
        wr(4'h4, 16'h00aa);
        wr(4'h2, 16'hc002);
        rd(4'h2, v);
        check(24'(v & 16'ha000), 24'h002000);
        wr(4'h2, 16'h0000);
        $display("test lock finished");
        core.op(1'b1, 1'b0, 1'b0, 16'h0010, 16'h0000, v);
        go(2'h3, 1'b0);
        core.op(1'b1, 1'b0, 1'b0, 16'h07fe, 16'h0000, v);
        go(2'h3, 1'b1);
        foreach (eb[i])
            cw(eb[i], 24'hffffff);
        $display("test erase finished");
        for (int i = 0; i < 64; i++)
            tww(16'(2 * i), 24'hffffff);
        tww(16'h0000, 24'h561234);
        tww(16'h0002, 24'h000000);
        tww(16'h0002, 24'h9abcde);
        core.op(1'b1, 1'b0, 1'b1, 16'h0004, 16'h0012, v);
        core.op(1'b1, 1'b1, 1'b1, 16'h0006, 16'h0033, v);
        cw(16'h0000, 24'hffffff);
        go(2'h2, 1'b1);
        cw(16'h0000, 24'h561234);
        cw(16'h0002, 24'h9abcde);
        cw(16'h0004, 24'hffff12);
        cw(16'h0006, 24'h33ffff);
        core.op(1'b0, 1'b0, 1'b1, 16'h0001, 16'h0000, v);
        check(24'(v), 24'h000012);
        core.op(1'b0, 1'b1, 1'b1, 16'h0001, 16'h0000, v);
        check(24'(v), 24'h000000);
        cw(16'h0080, 24'hffffff);
        $display("test row finished");
        tww(16'h0008, 24'h000000);
        tww(16'h000a, 24'h0f0f0f);
        go(2'h3, 1'b0);
        go(2'h1, 1'b0);
        cw(16'h000a, 24'h0f0f0f);
        cw(16'h0008, 24'hffffff);
        $display("test word finished");
        wr(4'h0, 16'h0080);
        cw(16'h0000, 24'hffffff);
        wr(4'h0, 16'h0000);
        $display("test config finished");
        final_report();
    end
endmodule // tb_top
`default_nettype wire
